// File: rcm_top.v
// Mode and channel control of an eight-channel relay driver
//
// Notes on behaviour
// (R1) Power-on reset restores every register default and enters idle mode.
// (R2) Reset pin low holds registers at default and quiets activity.
// (R3) Fail-safe pin high enters direct-drive mode and clears registers.
// (R4) In fail-safe, input pins one to four drive outputs one to four.
// (R5) In fail-safe, outputs five to eight stay off.
// (R6) In fail-safe, bus traffic is ignored; writes change nothing.
// (R7) Fail-safe pin beats reset pin; standby wakes into fail-safe.
// (R8) Leaving fail-safe resets registers, then standby or idle per reset pin.
// (R9) First transfer after fail-safe ends returns the transmission error flag; here only a read returns it, writes leave it set.
// (R10) Per-channel select field picks which input pin controls the channel.
// (R11) In pin mode, selected pin high turns channel on, low off.
// (R12) Floating input pins count as low and switch channels off.
// (R13) Outside pin mode, the on/off bit drives the channel.
// (R14) Fail-safe pin falling ends the mode; reset pin chooses next mode.
// (R15) Idle keeps all outputs off until commanded or pin-driven.
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "rcm_defines.vh"

module rcm_top (
   input  wire        sys_clk,
   input  wire        rstn,
   input  wire        fail_safe_drive_pin,
   input  wire        reset_pin_n,
   input  wire        direct_input_1,
   input  wire        direct_input_2,
   input  wire        direct_input_3,
   input  wire        direct_input_4,
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output wire [31:0] avs_readdata,
   output wire        avs_waitrequest,
   output wire        irq,
   output wire        channel_output_1,
   output wire        channel_output_2,
   output wire        channel_output_3,
   output wire        channel_output_4,
   output wire        channel_output_5,
   output wire        channel_output_6,
   output wire        channel_output_7,
   output wire        channel_output_8
);

   localparam [1:0] MODE_IDLE     = `RCM_MODE_IDLE;
   localparam [1:0] MODE_STANDBY  = `RCM_MODE_STANDBY;
   localparam [1:0] MODE_FAILSAFE = `RCM_MODE_FAILSAFE;

   wire [3:0]  pin_lvl;
   wire        fs_lvl;
   wire        rst_pin_lvl;
   wire [7:0]  drive_d;

   reg  [1:0]  mode_q;
   reg  [1:0]  mode_d;
   reg  [7:0]  chan_on_q;
   reg  [7:0]  in_mode_q;
   reg  [15:0] in_sel_q;
   reg  [7:0]  out_q;
   reg         ter_q;
   reg         ack_q;
   reg  [31:0] rdata_q;
   reg  [31:0] rdata_d;
   reg  [`RCM_IRQ_W-1:0] irq_stat_q;
   reg  [`RCM_IRQ_W-1:0] irq_en_q;

   wire [3:0] pin_raw;
   assign pin_raw = {direct_input_4, direct_input_3, direct_input_2, direct_input_1};

   // Pins reset low, so a floating or pulled-down input reads as off
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_in_sync
         rcm_pin_sync #(
            .RESET_VAL (1'b0)
         ) u_sync (
            .sys_clk (sys_clk),
            .rstn    (rstn),
            .pin_in  (pin_raw[gi]),
            .level   (pin_lvl[gi])                // [R12]
         );
      end
   endgenerate

   rcm_pin_sync #(
      .RESET_VAL (1'b0)
   ) u_fs_sync (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .pin_in  (fail_safe_drive_pin),
      .level   (fs_lvl)
   );

   // Reset pin starts released so power-on lands in idle, not standby
   rcm_pin_sync #(
      .RESET_VAL (1'b1)
   ) u_rst_sync (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .pin_in  (reset_pin_n),
      .level   (rst_pin_lvl)
   );

   // Mode selection
   wire fs_leave;
   assign fs_leave = (mode_q == MODE_FAILSAFE) && !fs_lvl;

   always @* begin
      mode_d = mode_q;
      if (fs_lvl) begin
         mode_d = MODE_FAILSAFE;                  // [R3] [R7]
      end else begin
         case (mode_q)
            MODE_FAILSAFE: begin
               // Falling fail-safe level ends the mode in this cycle
               if (!rst_pin_lvl) begin
                  mode_d = MODE_STANDBY;          // [R8] [R14]
               end else begin
                  mode_d = MODE_IDLE;             // [R8] [R14]
               end
            end
            MODE_IDLE: begin
               if (!rst_pin_lvl) begin
                  mode_d = MODE_STANDBY;          // [R2]
               end
            end
            MODE_STANDBY: begin
               if (rst_pin_lvl) begin
                  mode_d = MODE_IDLE;
               end
            end
            default: begin
               mode_d = MODE_IDLE;
            end
         endcase
      end
   end

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         mode_q <= MODE_IDLE;                     // [R1]
      end else begin
         mode_q <= mode_d;
      end
   end

   // Register clearing and write acceptance
   // IRQ enable stays out of the clear so the mask survives standby
   wire regs_clear;
   assign regs_clear = fs_lvl || (mode_q == MODE_FAILSAFE) || !rst_pin_lvl;

   wire bus_req;
   wire bus_done;
   wire rd_done;
   wire wr_ok;
   assign bus_req  = avs_read || avs_write;
   assign bus_done = bus_req && ack_q;
   assign rd_done  = bus_done && avs_read;
   // Any write while not in idle mode is dropped, including the irq registers
   assign wr_ok    = avs_write && ack_q && (mode_q == MODE_IDLE) && !regs_clear; // [R6]

   wire sel_chan_on;
   wire sel_in_mode;
   wire sel_in_sel;
   wire sel_stat;
   wire sel_irq_stat;
   wire sel_irq_en;
   wire sel_irq_clr;
   assign sel_chan_on  = (avs_address == `RCM_OFS_CHAN_ON);
   assign sel_in_mode  = (avs_address == `RCM_OFS_IN_MODE);
   assign sel_in_sel   = (avs_address == `RCM_OFS_IN_SEL);
   assign sel_stat     = (avs_address == `RCM_OFS_MODE_STAT);
   assign sel_irq_stat = (avs_address == `RCM_OFS_IRQ_STAT);
   assign sel_irq_en   = (avs_address == `RCM_OFS_IRQ_EN);
   assign sel_irq_clr  = (avs_address == `RCM_OFS_IRQ_CLR);

   // Per-register write strobes; every one passes the mode gate in wr_ok
   wire we_chan_on;
   wire we_in_mode;
   wire we_in_sel_lo;
   wire we_in_sel_hi;
   wire we_irq_en;
   wire we_irq_clr;
   assign we_chan_on   = wr_ok && sel_chan_on && avs_byteenable[0];
   assign we_in_mode   = wr_ok && sel_in_mode && avs_byteenable[0];
   assign we_in_sel_lo = wr_ok && sel_in_sel && avs_byteenable[0];
   assign we_in_sel_hi = wr_ok && sel_in_sel && avs_byteenable[1];
   assign we_irq_en    = wr_ok && sel_irq_en && avs_byteenable[0];
   assign we_irq_clr   = wr_ok && sel_irq_clr && avs_byteenable[0];

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         chan_on_q <= `RCM_RST_CHAN_ON;           // [R1]
         in_mode_q <= `RCM_RST_IN_MODE;           // [R1]
         in_sel_q  <= `RCM_RST_IN_SEL;            // [R1]
      end else if (regs_clear) begin
         chan_on_q <= `RCM_RST_CHAN_ON;           // [R2] [R3] [R8]
         in_mode_q <= `RCM_RST_IN_MODE;           // [R2] [R3] [R8]
         in_sel_q  <= `RCM_RST_IN_SEL;            // [R2] [R3] [R8]
      end else if (wr_ok) begin
         if (we_chan_on) begin
            chan_on_q <= avs_writedata[7:0];      // [R13]
         end
         if (we_in_mode) begin
            in_mode_q <= avs_writedata[7:0];      // [R11]
         end
         if (we_in_sel_lo) begin
            in_sel_q[7:0] <= avs_writedata[7:0];  // [R10]
         end
         if (we_in_sel_hi) begin
            in_sel_q[15:8] <= avs_writedata[15:8]; // [R10]
         end
      end
   end

   // Channel drive
   // Taken from mode_d so the outputs switch on the same edge as the mode
   wire in_fs;
   assign in_fs = (mode_d == MODE_FAILSAFE);

   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_chan
         rcm_chan #(
            .CH (gi)
         ) u_chan (
            .fail_safe (in_fs),
            .on_bit    (chan_on_q[gi]),
            .pin_mode  (in_mode_q[gi]),
            .pin_sel   (in_sel_q[2*gi+1:2*gi]),
            .pins      (pin_lvl),
            .drive     (drive_d[gi])
         );
      end
   endgenerate

   // Standby and the exit cycle from fail-safe force every channel off
   // A stale serial pattern never shows for a cycle after leaving fail-safe
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         out_q <= 8'h00;                          // [R15]
      end else if (in_fs) begin
         out_q <= drive_d;                        // [R4] [R5]
      end else if ((mode_d != MODE_IDLE) || fs_leave) begin
         out_q <= 8'h00;                          // [R2] [R8]
      end else begin
         out_q <= drive_d;                        // [R15]
      end
   end

   assign channel_output_1 = out_q[0];
   assign channel_output_2 = out_q[1];
   assign channel_output_3 = out_q[2];
   assign channel_output_4 = out_q[3];
   assign channel_output_5 = out_q[4];
   assign channel_output_6 = out_q[5];
   assign channel_output_7 = out_q[6];
   assign channel_output_8 = out_q[7];

   // Transmission error flag: only a read that carried it consumes it, so a
   // flag raised while a read is in flight waits for the next read
   wire ter_take;
   assign ter_take = rd_done && rdata_q[`RCM_TER_BIT];

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ter_q <= 1'b0;
      end else if (fs_leave) begin
         ter_q <= 1'b1;                           // [R9]
      end else if (ter_take) begin
         ter_q <= 1'b0;                           // [R9]
      end
   end

   // Interrupt status, set wins over clear
   // Events come from mode changes, so a held pin raises each flag once
   wire [`RCM_IRQ_W-1:0] irq_evt;
   wire [`RCM_IRQ_W-1:0] irq_clr;
   assign irq_evt[`RCM_IRQ_FS_ENTER] = (mode_d == MODE_FAILSAFE) && (mode_q != MODE_FAILSAFE);
   assign irq_evt[`RCM_IRQ_FS_LEAVE] = fs_leave;
   assign irq_evt[`RCM_IRQ_STANDBY]  = (mode_d == MODE_STANDBY) && (mode_q != MODE_STANDBY);
   assign irq_clr = we_irq_clr ? avs_writedata[`RCM_IRQ_W-1:0] : {`RCM_IRQ_W{1'b0}};

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq_stat_q <= {`RCM_IRQ_W{1'b0}};
         irq_en_q   <= `RCM_RST_IRQ_EN;
      end else begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
         if (we_irq_en) begin
            irq_en_q <= avs_writedata[`RCM_IRQ_W-1:0];
         end
      end
   end

   assign irq = |(irq_stat_q & irq_en_q);

   // Read mux, captured during the wait cycle
   // The flag rides on every address so any first read reports it
   always @* begin
      rdata_d = 32'h00000000;
      if (sel_chan_on) begin
         rdata_d[7:0] = chan_on_q;
      end else if (sel_in_mode) begin
         rdata_d[7:0] = in_mode_q;
      end else if (sel_in_sel) begin
         rdata_d[15:0] = in_sel_q;
      end else if (sel_stat) begin
         rdata_d[`RCM_STAT_MODE_LSB+1:`RCM_STAT_MODE_LSB] = mode_q;
         rdata_d[`RCM_STAT_OUT_LSB+7:`RCM_STAT_OUT_LSB]   = out_q;
         rdata_d[`RCM_STAT_PINS_LSB+3:`RCM_STAT_PINS_LSB] = pin_lvl;
         rdata_d[`RCM_STAT_FSPIN_BIT]  = fs_lvl;
         rdata_d[`RCM_STAT_RSTPIN_BIT] = rst_pin_lvl;
      end else if (sel_irq_stat) begin
         rdata_d[`RCM_IRQ_W-1:0] = irq_stat_q;
      end else if (sel_irq_en) begin
         rdata_d[`RCM_IRQ_W-1:0] = irq_en_q;
      end
      rdata_d[`RCM_TER_BIT] = ter_q;              // [R9]
   end

   // One wait cycle per transfer keeps the read path registered
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h00000000;
      end else begin
         ack_q <= bus_req && !ack_q;
         if (avs_read && !ack_q) begin
            rdata_q <= rdata_d;
         end
      end
   end

   assign avs_waitrequest = bus_req && !ack_q;
   assign avs_readdata    = rdata_q;

endmodule // rcm_top

`default_nettype wire

// File: rcm_defines.vh
// Constants for the relay channel mode control block
`ifndef RCM_DEFINES_VH
`define RCM_DEFINES_VH

// Register byte offsets on the Avalon-MM slave
`define RCM_ADDR_W          8
`define RCM_OFS_CHAN_ON     8'h00
`define RCM_OFS_IN_MODE     8'h04
`define RCM_OFS_IN_SEL      8'h08
`define RCM_OFS_MODE_STAT   8'h0c
`define RCM_OFS_IRQ_STAT    8'h10
`define RCM_OFS_IRQ_EN      8'h14
`define RCM_OFS_IRQ_CLR     8'h18

// Reset values
`define RCM_RST_CHAN_ON     8'h00
`define RCM_RST_IN_MODE     8'h00
`define RCM_RST_IN_SEL      16'h0000
`define RCM_RST_IRQ_EN      3'h0

// Mode codes, also reported in the mode status register
`define RCM_MODE_IDLE       2'h0
`define RCM_MODE_STANDBY    2'h1
`define RCM_MODE_FAILSAFE   2'h2

// Field positions
`define RCM_STAT_MODE_LSB   0
`define RCM_STAT_OUT_LSB    8
`define RCM_STAT_PINS_LSB   16
`define RCM_STAT_FSPIN_BIT  20
`define RCM_STAT_RSTPIN_BIT 21
`define RCM_TER_BIT         31

// Interrupt event bits
`define RCM_IRQ_W           3
`define RCM_IRQ_FS_ENTER    0
`define RCM_IRQ_FS_LEAVE    1
`define RCM_IRQ_STANDBY     2

`endif

// File: rcm_pin_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module rcm_pin_sync #(
   parameter RESET_VAL = 1'b0
) (
   input  wire sys_clk,
   input  wire rstn,
   input  wire pin_in,
   output wire level
);

   reg s1_q;
   reg s2_q;
   reg s3_q;
   reg level_q;

   // The output follows only once the second and third stages agree
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s1_q    <= RESET_VAL;
         s2_q    <= RESET_VAL;
         s3_q    <= RESET_VAL;
         level_q <= RESET_VAL;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end

   assign level = level_q;

endmodule // rcm_pin_sync

`default_nettype wire

// File: rcm_chan.v
// Next output level of one relay channel
`timescale 1ns/1ps
`default_nettype none

module rcm_chan #(
   parameter CH = 0
) (
   input  wire       fail_safe,
   input  wire       on_bit,
   input  wire       pin_mode,
   input  wire [1:0] pin_sel,
   input  wire [3:0] pins,
   output reg        drive
);

   always @* begin
      drive = 1'b0;
      if (fail_safe) begin
         // Only channels one to four follow their own pin
         if (CH < 4) begin
            drive = pins[CH % 4];                 // [R4]
         end else begin
            drive = 1'b0;                         // [R5]
         end
      end else if (pin_mode) begin
         drive = pins[pin_sel];                   // [R10] [R11]
      end else begin
         drive = on_bit;                          // [R13]
      end
   end

endmodule // rcm_chan

`default_nettype wire

// File: rcm_chk_assertions.sv
// Port checker for the relay mode control block
`timescale 1ns/1ps
`default_nettype none
module rcm_chk (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic fail_safe_drive_pin,
   input wire logic reset_pin_n,
   input wire logic direct_input_1,
   input wire logic direct_input_2,
   input wire logic direct_input_3,
   input wire logic direct_input_4,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic irq,
   input wire logic channel_output_1,
   input wire logic channel_output_2,
   input wire logic channel_output_3,
   input wire logic channel_output_4,
   input wire logic channel_output_5,
   input wire logic channel_output_6,
   input wire logic channel_output_7,
   input wire logic channel_output_8
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   wire [3:0] din = {direct_input_4, direct_input_3, direct_input_2, direct_input_1};
   wire [7:0] co = {channel_output_8, channel_output_7, channel_output_6, channel_output_5,
                    channel_output_4, channel_output_3, channel_output_2, channel_output_1};
   // Repeat counts leave room for the pin synchroniser lag
   fs_high_off_a: assert property (
      fail_safe_drive_pin [*7] |-> co[7:4] == 4'h0)
      else $error("upper outputs on in fail-safe");
   fs_route_a: assert property (
      (fail_safe_drive_pin && $stable(din)) [*8] |-> co[3:0] == din)
      else $error("direct route wrong in fail-safe");
   rst_pin_off_a: assert property (
      (!reset_pin_n && !fail_safe_drive_pin) [*7] |-> co == 8'h00)
      else $error("output on while reset pin low");
   post_reset_off_a: assert property ($rose(rstn) |-> co == 8'h00)
      else $error("output on after reset");
   irq_reset_low_a: assert property ($rose(rstn) |-> !irq)
      else $error("irq high after reset");
   rd_wait_a: assert property (
      avs_read && avs_waitrequest ##1 avs_read |-> !avs_waitrequest)
      else $error("read not answered after one wait");
   wr_wait_a: assert property (
      $rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("write wait state wrong");
   no_wait_idle_a: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
      else $error("waitrequest without request");
endmodule // rcm_chk
bind rcm_top rcm_chk u_chk (.*);
`default_nettype wire

// File: rcm_host.sv
// Host model: bus master and pin drivers
`timescale 1ns/1ps
`default_nettype none
module rcm_host (
   input  wire logic        sys_clk,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest,
   output var  logic [7:0]  avs_address,
   output var  logic        avs_read,
   output var  logic        avs_write,
   output var  logic [31:0] avs_writedata,
   output var  logic        fs_pin,
   output var  logic        rst_pin_n,
   output var  logic [3:0]  din
);
   int gap = 0;
   initial begin
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      {fs_pin, din} = '0;
      rst_pin_n = 1'b1;
   end
   // Request held until waitrequest is sampled low at a rising edge; one idle edge after
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      {avs_read, avs_write} <= 2'b00;
      repeat (gap + 1) @(posedge sys_clk);
   endtask
endmodule // rcm_host
`default_nettype wire

// File: tb.sv
// Self-checking bench for the relay mode control block
`timescale 1ns/1ps
`default_nettype none
`include "rcm_defines.vh"
module tb;
   logic        sys_clk = 1'b0;
   logic        rstn = 1'b0;
   wire  [7:0]  adr;
   wire         rd, wr, wq, irq, fs, rp;
   wire  [31:0] wd, q;
   wire  [3:0]  din;
   wire  [7:0]  co;
   int          error_cnt = 0;
   int          comparisons = 0;
   logic [31:0] r;
   always #50 sys_clk = ~sys_clk;
   rcm_host u_host (.sys_clk(sys_clk), .avs_readdata(q), .avs_waitrequest(wq),
      .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .fs_pin(fs), .rst_pin_n(rp), .din(din));
   rcm_top u_rcm_top (.sys_clk(sys_clk), .rstn(rstn), .fail_safe_drive_pin(fs),
      .reset_pin_n(rp), .direct_input_1(din[0]), .direct_input_2(din[1]),
      .direct_input_3(din[2]), .direct_input_4(din[3]), .avs_address(adr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'h3),
      .avs_readdata(q), .avs_waitrequest(wq), .irq(irq),
      .channel_output_1(co[0]), .channel_output_2(co[1]), .channel_output_3(co[2]),
      .channel_output_4(co[3]), .channel_output_5(co[4]), .channel_output_6(co[5]),
      .channel_output_7(co[6]), .channel_output_8(co[7]));
   task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      u_host.xfer(1'b1, a, d, x);
   endtask
   task automatic rreg(input logic [7:0] a);
      u_host.xfer(1'b0, a, 32'h0, r);
   endtask
   // Seven edges covers the synchroniser, agreement filter and output flop
   task automatic pins(input logic f, input logic p, input logic [3:0] d);
      u_host.fs_pin <= f;
      u_host.rst_pin_n <= p;
      u_host.din <= d;
      repeat (7) @(posedge sys_clk);
   endtask
   task automatic t_reset;
      logic [7:0] a[5] = '{`RCM_OFS_CHAN_ON, `RCM_OFS_IN_MODE, `RCM_OFS_IN_SEL,
                           `RCM_OFS_IRQ_EN, 8'h40};
      foreach (a[i]) begin
         rreg(a[i]);
         chk(r, 32'h0, "reg");
      end
      rreg(`RCM_OFS_MODE_STAT);
      chk(r, 32'h1 << `RCM_STAT_RSTPIN_BIT, "stat");
      $display("test reset done");
   endtask
   task automatic t_serial;
      wreg(`RCM_OFS_CHAN_ON, 32'ha5);
      rreg(`RCM_OFS_CHAN_ON);
      chk({r, co}, {32'ha5, 8'ha5}, "on");
      $display("test serial done");
   endtask
   task automatic t_pinmode;
      logic [3:0] p;
      wreg(`RCM_OFS_CHAN_ON, 32'h0f);
      wreg(`RCM_OFS_IN_SEL, 32'h1be4);
      wreg(`RCM_OFS_IN_MODE, 32'hf0);
      for (int i = 0; i < 5; i++) begin
         p = 4'h1 << i;
         pins(1'b0, 1'b1, p);
         chk(co, {p[0], p[1], p[2], p[3], 4'hf}, "pin");
      end
      $display("test pin mode done");
   endtask
   task automatic t_failsafe;
      wreg(`RCM_OFS_CHAN_ON, 32'hff);
      wreg(`RCM_OFS_IN_MODE, 32'h0);
      pins(1'b1, 1'b1, 4'h5);
      chk(co, 8'h05, "fs");
      wreg(`RCM_OFS_CHAN_ON, 32'hff);
      rreg(`RCM_OFS_CHAN_ON);
      chk({r, co}, {32'h0, 8'h05}, "fs reg");
      pins(1'b0, 1'b0, 4'h5);
      rreg(`RCM_OFS_MODE_STAT);
      chk({r[31], r[1:0], co}, {1'b1, `RCM_MODE_STANDBY, 8'h0}, "exit");
      rreg(`RCM_OFS_MODE_STAT);
      chk(r[31], 1'b0, "flag");
      pins(1'b1, 1'b0, 4'ha);
      rreg(`RCM_OFS_MODE_STAT);
      chk({r[1:0], co}, {`RCM_MODE_FAILSAFE, 8'h0a}, "wake");
      pins(1'b0, 1'b1, 4'ha);
      rreg(`RCM_OFS_MODE_STAT);
      chk({r[31], r[1:0], co}, {1'b1, `RCM_MODE_IDLE, 8'h0}, "idle");
      $display("test fail-safe done");
   endtask
   task automatic t_standby_irq;
      wreg(`RCM_OFS_IRQ_CLR, 32'h7);
      wreg(`RCM_OFS_IRQ_EN, 32'h4);
      wreg(`RCM_OFS_CHAN_ON, 32'hff);
      chk(irq, 1'b0, "irq");
      pins(1'b0, 1'b0, 4'h0);
      chk(co, 8'h0, "stby");
      pins(1'b0, 1'b1, 4'h0);
      rreg(`RCM_OFS_CHAN_ON);
      chk(r, 32'h0, "def");
      rreg(`RCM_OFS_IRQ_STAT);
      chk(r[2:0], 3'h4, "stat");
      wreg(`RCM_OFS_IRQ_EN, 32'h0);
      chk(irq, 1'b0, "mask");
      wreg(`RCM_OFS_IRQ_EN, 32'h4);
      chk(irq, 1'b1, "irq on");
      wreg(`RCM_OFS_IRQ_CLR, 32'h4);
      chk(irq, 1'b0, "clr");
      $display("test standby irq done");
   endtask
   task automatic t_por;
      wreg(`RCM_OFS_CHAN_ON, 32'h3c);
      wreg(`RCM_OFS_IN_MODE, 32'h81);
      wreg(`RCM_OFS_IRQ_EN, 32'h7);
      chk(co, 8'h3c, "pre por");
      rstn <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk(co, 8'h00, "por out");
      rstn <= 1'b1;
      @(posedge sys_clk);
      rreg(`RCM_OFS_CHAN_ON);
      chk(r, 32'h0, "por on");
      rreg(`RCM_OFS_IN_MODE);
      chk(r, 32'h0, "por mode");
      rreg(`RCM_OFS_IRQ_EN);
      chk({r, irq}, 33'h0, "por en");
      rreg(`RCM_OFS_MODE_STAT);
      chk(r, 32'h1 << `RCM_STAT_RSTPIN_BIT, "por stat");
      $display("test power-on reset done");
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      t_reset;
      t_serial;
      t_pinmode;
      t_failsafe;
      t_standby_irq;
      t_por;
      report_and_stop;
   end
   initial begin
      #500000;
      error_cnt++;
      report_and_stop;
   end
endmodule // tb
`default_nettype wire
